// >>> rcat_pkg.sv
// Overview of operation
// - Cutoff cycling runs only when the heat input is set non-latching.
// - First heat alarm turns outputs on and starts the initial cutoff interval.
// - Initial interval expiry silences the outputs the heat alarm turned on only if no alarm is present.
// - Alarm still present at initial expiry keeps outputs on, reruns initial interval.
// - No alarm at initial expiry turns the programmed outputs off until a fresh threshold crossing.
// - Fresh threshold crossing after silencing reactivates; cyclic interval expiry silences again.
// - Only fresh crossings after silencing reactivate; each lasts the cyclic duration.
// - Cutoff durations span 0 to 180, in seconds or minutes as configured.
// - Full-delay mode reloads full delay on abort, restarts full count on release.
// - Countdown state persists in every abort mode until a system reset.
// - Ten-second-hold mode keeps counting under abort, halting at 10 seconds.
// - Ten-second-hold resumes from 10 on release; abort arriving below 10 reloads 10.
// - Extended mode loads full delay plus 90 seconds on abort, counts on release.
// - Freeze mode holds remaining time while abort active, continues on release.
// - No-interrupt mode ignores abort at all times and counts straight down to zero.
// - After initial cutoff, held manual switch reactivates extinguishing outputs.
// - Alarm, abort, supervisory and waterflow contacts have per-input polarity.
package rcat_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ITL    = 8'h04;
  localparam logic [7:0] OFS_CTL    = 8'h08;
  localparam logic [7:0] OFS_DELAY  = 8'h0C;
  localparam logic [7:0] OFS_CMD    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_REMAIN = 8'h18;

  // Field positions
  localparam int CMD_SYS_RESET = 0;
  localparam int CMD_START     = 1;

  // Reset values
  localparam logic [11:0] CTRL_RST  = 12'h001;
  localparam logic [7:0]  ITL_RST   = 8'h1E;
  localparam logic [7:0]  CTL_RST   = 8'h1E;
  localparam logic [15:0] DELAY_RST = 16'h001E;

  // Counts
  localparam int          NUM_HEAT     = 4;
  localparam logic [7:0]  CUTOFF_MAX   = 8'hB4;
  localparam logic [15:0] HOLD_SECS    = 16'h000A;
  localparam logic [15:0] EXTRA_SECS   = 16'h005A;
  localparam logic [5:0]  SECS_PER_MIN = 6'h3C;
  localparam int          CLK_NS       = 10;
  localparam int          SEC_NS       = 1000000000;
  localparam int          CYC_PER_SEC  = SEC_NS / CLK_NS;

  typedef enum logic [2:0] {
    AB_FULL, AB_HOLD10, AB_EXTEND, AB_FREEZE, AB_NOINT
  } rcat_abort_mode_t;

  typedef struct packed {
    logic [3:0] pol_heat;
    logic       pol_wflow;
    logic       pol_supervisory_input;
    logic       pol_abort;
    logic [2:0] abort_mode;
    logic       unit_min;
    logic       nonlatch;
  } rcat_ctrl_t;

  typedef struct packed {
    logic paddr_ok;
    logic wr;
    logic rd;
  } rcat_acc_t;

endpackage

// >>> rcat_top.sv
`timescale 1ns/1ns
module rcat_top #(
  parameter int CYC_PER_SEC = rcat_pkg::CYC_PER_SEC
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Field contacts
  input  wire logic [rcat_pkg::NUM_HEAT-1:0] alarm_contact_monitor,
  input  wire logic                          abort_input,
  input  wire logic                          manual_reactivate_switch,
  input  wire logic                          supervisory_input,
  input  wire logic                          waterflow_input,
  // Output enables
  output logic                               notify_out_en,
  output logic                               extinguish_out_en,
  output logic                               release_out_en,
  output logic                               supervisory_active,
  output logic                               waterflow_active
);

  typedef enum logic [2:0] {
    CO_IDLE, CO_LATCH, CO_INIT, CO_SILENT, CO_CYC
  } rcat_co_state_t;

  typedef enum logic [1:0] {
    CD_IDLE, CD_RUN, CD_DONE
  } rcat_cd_state_t;

  rcat_pkg::rcat_ctrl_t ctrl_q;
  logic [7:0]           itl_q;
  logic [7:0]           ctl_q;
  logic [15:0]          delay_q;
  logic [31:0]          prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  rcat_pkg::rcat_acc_t  acc;
  logic                 sys_clr;
  logic                 cd_start;
  logic [7:0]           wr_clamp;

  // Contact conditioning
  logic [rcat_pkg::NUM_HEAT-1:0] heat_s1_q;
  logic [rcat_pkg::NUM_HEAT-1:0] heat_s2_q;
  logic [rcat_pkg::NUM_HEAT-1:0] heat_d_q;
  logic [rcat_pkg::NUM_HEAT-1:0] heat_lvl;
  logic [rcat_pkg::NUM_HEAT-1:0] heat_rise;
  logic [3:0]                    ct_s1_q;
  logic [3:0]                    ct_s2_q;
  logic                          abort_d_q;
  logic                          abort_lvl;
  logic                          abort_rise;
  logic                          squirt_lvl;

  // Time base
  logic [31:0] sec_cnt_q;
  logic [5:0]  min_cnt_q;
  logic        sec_tick_q;
  logic        min_tick_q;
  logic        co_tick;

  // Cutoff and countdown
  rcat_co_state_t   co_state_q;
  logic [7:0]       co_rem_q;
  logic             co_expire;
  logic             any_heat;
  rcat_cd_state_t   cd_state_q;
  logic [15:0]      cd_rem_q;
  rcat_pkg::rcat_abort_mode_t mode;
  logic             abort_eff;
  logic             outs_on;
  logic             after_init;

  // APB decode
  assign acc.wr = psel & penable & pready_q & pwrite;
  assign acc.rd = psel & ~penable & ~pwrite;
  assign acc.paddr_ok = (paddr == rcat_pkg::OFS_CTRL) || (paddr == rcat_pkg::OFS_ITL) ||
                        (paddr == rcat_pkg::OFS_CTL) || (paddr == rcat_pkg::OFS_DELAY) ||
                        (paddr == rcat_pkg::OFS_CMD) || (paddr == rcat_pkg::OFS_STATUS) ||
                        (paddr == rcat_pkg::OFS_REMAIN);
  assign sys_clr  = acc.wr && paddr == rcat_pkg::OFS_CMD && pwdata[rcat_pkg::CMD_SYS_RESET];
  assign cd_start = acc.wr && paddr == rcat_pkg::OFS_CMD && pwdata[rcat_pkg::CMD_START];
  assign wr_clamp = (pwdata[31:8] != 24'h000000 || pwdata[7:0] > rcat_pkg::CUTOFF_MAX) ?
                    rcat_pkg::CUTOFF_MAX : pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~acc.paddr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (acc.rd) begin
      unique case (paddr)
        rcat_pkg::OFS_CTRL:   prdata_q <= {20'h00000, ctrl_q};
        rcat_pkg::OFS_ITL:    prdata_q <= {24'h000000, itl_q};
        rcat_pkg::OFS_CTL:    prdata_q <= {24'h000000, ctl_q};
        rcat_pkg::OFS_DELAY:  prdata_q <= {16'h0000, delay_q};
        rcat_pkg::OFS_STATUS: prdata_q <= {18'h00000, heat_lvl, 1'b0, co_state_q,
                                           cd_state_q, abort_lvl, squirt_lvl,
                                           extinguish_out_en, notify_out_en};
        rcat_pkg::OFS_REMAIN: prdata_q <= {co_rem_q, 8'h00, cd_rem_q};
        default:              prdata_q <= 32'h00000000;
      endcase
    end else begin
      prdata_q <= 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= rcat_pkg::CTRL_RST;
      itl_q   <= rcat_pkg::ITL_RST;
      ctl_q   <= rcat_pkg::CTL_RST;
      delay_q <= rcat_pkg::DELAY_RST;
    end else if (acc.wr) begin
      if (paddr == rcat_pkg::OFS_CTRL) begin
        ctrl_q <= rcat_pkg::rcat_ctrl_t'(pwdata[11:0]);
      end
      if (paddr == rcat_pkg::OFS_ITL) begin
        itl_q <= wr_clamp;
      end
      if (paddr == rcat_pkg::OFS_CTL) begin
        ctl_q <= wr_clamp;
      end
      if (paddr == rcat_pkg::OFS_DELAY) begin
        delay_q <= pwdata[15:0];
      end
    end
  end

  // Heat detector sync, polarity and edge per input
  genvar gi;
  generate
    for (gi = 0; gi < rcat_pkg::NUM_HEAT; gi++) begin : g_heat
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          heat_s1_q[gi] <= 1'b0;
          heat_s2_q[gi] <= 1'b0;
          heat_d_q[gi]  <= 1'b0;
        end else begin
          heat_s1_q[gi] <= alarm_contact_monitor[gi];
          heat_s2_q[gi] <= heat_s1_q[gi];
          heat_d_q[gi]  <= heat_lvl[gi];
        end
      end
      assign heat_lvl[gi]  = heat_s2_q[gi] ^ ctrl_q.pol_heat[gi];
      assign heat_rise[gi] = heat_lvl[gi] & ~heat_d_q[gi];
    end
  endgenerate

  // Other contacts: abort, squirt, supervisory, waterflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ct_s1_q   <= 4'h0;
      ct_s2_q   <= 4'h0;
      abort_d_q <= 1'b0;
    end else begin
      ct_s1_q   <= {waterflow_input, supervisory_input, manual_reactivate_switch,
                    abort_input};
      ct_s2_q   <= ct_s1_q;
      abort_d_q <= abort_lvl;
    end
  end

  assign abort_lvl  = ct_s2_q[0] ^ ctrl_q.pol_abort;
  assign abort_rise = abort_lvl & ~abort_d_q;
  assign squirt_lvl = ct_s2_q[1];
  assign any_heat   = |heat_lvl;

  // Second and minute tick enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_q  <= 32'h00000000;
      min_cnt_q  <= 6'h00;
      sec_tick_q <= 1'b0;
      min_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= 1'b0;
      min_tick_q <= 1'b0;
      if (sec_cnt_q >= 32'(CYC_PER_SEC - 1)) begin
        sec_cnt_q  <= 32'h00000000;
        sec_tick_q <= 1'b1;
        if (min_cnt_q == rcat_pkg::SECS_PER_MIN - 6'h01) begin
          min_cnt_q  <= 6'h00;
          min_tick_q <= 1'b1;
        end else begin
          min_cnt_q <= min_cnt_q + 6'h01;
        end
      end else begin
        sec_cnt_q <= sec_cnt_q + 32'h00000001;
      end
    end
  end

  assign co_tick   = ctrl_q.unit_min ? min_tick_q : sec_tick_q;
  assign co_expire = (co_rem_q == 8'h00) || (co_tick && co_rem_q == 8'h01);

  // Thermal cycling cutoff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      co_state_q <= CO_IDLE;
      co_rem_q   <= 8'h00;
      after_init <= 1'b0;
    end else if (sys_clr) begin
      co_state_q <= CO_IDLE;
      co_rem_q   <= 8'h00;
      after_init <= 1'b0;
    end else begin
      unique case (co_state_q)
        CO_IDLE: begin
          if (any_heat) begin
            if (ctrl_q.nonlatch) begin
              co_state_q <= CO_INIT;
              co_rem_q   <= itl_q;
            end else begin
              co_state_q <= CO_LATCH;
            end
          end
        end
        CO_LATCH: begin
          co_state_q <= CO_LATCH;
        end
        CO_INIT: begin
          if (co_expire) begin
            after_init <= 1'b1;
            if (any_heat) begin
              co_rem_q <= itl_q;
            end else begin
              co_state_q <= CO_SILENT;
              co_rem_q   <= 8'h00;
            end
          end else if (co_tick) begin
            co_rem_q <= co_rem_q - 8'h01;
          end
        end
        CO_SILENT: begin
          if (|heat_rise) begin
            co_state_q <= CO_CYC;
            co_rem_q   <= ctl_q;
          end
        end
        CO_CYC: begin
          if (co_expire) begin
            co_state_q <= CO_SILENT;
            co_rem_q   <= 8'h00;
          end else if (co_tick) begin
            co_rem_q <= co_rem_q - 8'h01;
          end
        end
      endcase
    end
  end

  assign outs_on = (co_state_q == CO_LATCH) || (co_state_q == CO_INIT) ||
                   (co_state_q == CO_CYC);

  // Pre-release countdown with abort handling
  assign mode      = rcat_pkg::rcat_abort_mode_t'(ctrl_q.abort_mode);
  assign abort_eff = abort_lvl && !(mode == rcat_pkg::AB_NOINT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cd_state_q <= CD_IDLE;
      cd_rem_q   <= 16'h0000;
    end else if (sys_clr) begin
      cd_state_q <= CD_IDLE;
      cd_rem_q   <= 16'h0000;
    end else begin
      unique case (cd_state_q)
        CD_IDLE: begin
          if (cd_start) begin
            cd_state_q <= CD_RUN;
            cd_rem_q   <= delay_q;
          end
        end
        CD_RUN: begin
          if (cd_rem_q == 16'h0000) begin
            cd_state_q <= CD_DONE;
          end else begin
            case (mode)
              rcat_pkg::AB_HOLD10: begin
                if (abort_rise && cd_rem_q < rcat_pkg::HOLD_SECS) begin
                  cd_rem_q <= rcat_pkg::HOLD_SECS;
                end else if (sec_tick_q && (!abort_eff || cd_rem_q > rcat_pkg::HOLD_SECS)) begin
                  cd_rem_q <= cd_rem_q - 16'h0001;
                end
              end
              rcat_pkg::AB_EXTEND: begin
                if (abort_eff) begin
                  cd_rem_q <= abort_rise ? delay_q + rcat_pkg::EXTRA_SECS : cd_rem_q;
                end else if (sec_tick_q) begin
                  cd_rem_q <= cd_rem_q - 16'h0001;
                end
              end
              rcat_pkg::AB_FREEZE: begin
                if (!abort_eff && sec_tick_q) begin
                  cd_rem_q <= cd_rem_q - 16'h0001;
                end
              end
              rcat_pkg::AB_NOINT: begin
                if (sec_tick_q) begin
                  cd_rem_q <= cd_rem_q - 16'h0001;
                end
              end
              default: begin
                if (abort_eff) begin
                  cd_rem_q <= delay_q;
                end else if (sec_tick_q) begin
                  cd_rem_q <= cd_rem_q - 16'h0001;
                end
              end
            endcase
          end
        end
        CD_DONE: begin
          cd_state_q <= CD_DONE;
        end
      endcase
    end
  end

  // Output enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      notify_out_en      <= 1'b0;
      extinguish_out_en  <= 1'b0;
      release_out_en     <= 1'b0;
      supervisory_active <= 1'b0;
      waterflow_active   <= 1'b0;
    end else begin
      notify_out_en      <= outs_on;
      extinguish_out_en  <= outs_on || (after_init && !outs_on && squirt_lvl);
      release_out_en     <= cd_state_q == CD_DONE;
      supervisory_active <= ct_s2_q[2] ^ ctrl_q.pol_supervisory_input;
      waterflow_active   <= ct_s2_q[3] ^ ctrl_q.pol_wflow;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule

// >>> rcat_chk.sv
`timescale 1ns/1ns
module rcat_chk #(
  parameter int CYC_PER_SEC = 10
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Field and outputs
  input wire logic        manual_reactivate_switch,
  input wire logic        notify_out_en,
  input wire logic        extinguish_out_en,
  input wire logic        release_out_en
);
  logic clr_w;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign clr_w = psel && penable && pwrite && paddr == rcat_pkg::OFS_CMD && pwdata[0];

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_clear;
    psel && penable && pwrite && paddr == rcat_pkg::OFS_CMD && pwdata[0];
  endsequence

  property p_ready;
    s_setup |=> pready;
  endproperty
  property p_ready_cause;
    pready |-> $past(psel && !penable);
  endproperty
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_err_data;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  property p_notify_ext;
    notify_out_en |-> extinguish_out_en;
  endproperty
  property p_squirt;
    extinguish_out_en && !notify_out_en |-> $past(manual_reactivate_switch, 3);
  endproperty
  property p_rel_hold;
    release_out_en && !clr_w && !$past(clr_w) |=> release_out_en;
  endproperty
  property p_rel_clear;
    s_clear |-> ##2 !release_out_en;
  endproperty

  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  a_err_data: assert property (p_err_data) else $error("error response malformed");
  a_notify_ext: assert property (p_notify_ext) else $error("extinguish off with notify");
  a_squirt: assert property (p_squirt) else $error("extinguish without held switch");
  a_rel_hold: assert property (p_rel_hold) else $error("release dropped");
  a_rel_clear: assert property (p_rel_clear) else $error("release not cleared");
endmodule

// >>> rcat_field.sv
`timescale 1ns/1ns
module rcat_field (
  // Clock
  input  wire logic       pclk,
  // Bench requests {heat, wflow, supervisory_input, squirt, abort}
  input  wire logic [7:0] req,
  input  wire logic [6:0] pol,
  input  wire logic [2:0] lag,
  // Contacts
  output logic      [3:0] heat_c,
  output logic            abort_c,
  output logic            sq_c,
  output logic            sup_c,
  output logic            wf_c
);
  logic [7:0][7:0] hist = '0;
  logic [7:0]      now;

  // Abort station kept at station 1
  localparam int STATION = 1;

  always @(posedge pclk) begin
    hist <= {hist[6:0], req};
  end
  assign now     = hist[lag];
  assign heat_c  = now[7:4] ^ pol[6:3];
  assign wf_c    = now[3] ^ pol[2];
  assign sup_c   = now[2] ^ pol[1];
  assign abort_c = now[0] ^ pol[0];
  assign sq_c    = now[1];
endmodule

// >>> release_cutoff_and_abort_timer_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t: got %0h exp %0h", $time, (a), (b)); end end
module release_cutoff_and_abort_timer_tb_top;
  localparam int CPS = 10;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, req;
  logic [31:0] pwdata, prdata, r1;
  logic [6:0]  pol;
  logic [2:0]  lag;
  logic [3:0]  heat_c;
  logic        abort_c, sq_c, sup_c, wf_c;
  logic [4:0]  outs;
  logic [64:0] e;
  logic [64:0] exp_q[$];
  int          errors = 0;
  int          n_compared = 0;
  int          h, k, rr;
  int          rem[5] = '{15, 10, 105, 0, 0};
  logic [31:0] msk[5] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h0, 32'hFFFF};

  always #5 pclk = ~pclk;

  rcat_field u_field (.pclk(pclk), .req(req), .pol(pol), .lag(lag), .heat_c(heat_c),
    .abort_c(abort_c), .sq_c(sq_c), .sup_c(sup_c), .wf_c(wf_c));

  rcat_top #(.CYC_PER_SEC(CPS)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_contact_monitor(heat_c),
    .abort_input(abort_c), .manual_reactivate_switch(sq_c), .supervisory_input(sup_c),
    .waterflow_input(wf_c), .notify_out_en(outs[0]), .extinguish_out_en(outs[1]),
    .release_out_en(outs[2]), .supervisory_active(outs[3]), .waterflow_active(outs[4]));

  always @(negedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : {1'b1, 64'h1};
      `CHK(pslverr, e[64])
      `CHK(prdata & e[63:32], e[31:0])
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [64:0] x);
    exp_q.push_back(x);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r1 = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 65'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    apb(1'b0, a, 32'h0, {1'b0, m, v});
  endtask

  task automatic wait_out(input int i, input logic v, input int lim);
    k = 0;
    do begin @(negedge pclk); k++; end while (outs[i] !== v && k < lim);
    `CHK(outs[i], v)
    @(posedge pclk);
  endtask

  task automatic stay(input int i, input logic v, input int n);
    repeat (n) begin @(negedge pclk); `CHK(outs[i], v) end
    @(posedge pclk);
  endtask

  task automatic end_sim();
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    end_sim();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; req = 8'h00; pol = 7'h00; lag = 3'h0;
    void'($urandom(56));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(rcat_pkg::OFS_CTRL, 32'hFFF, 32'(rcat_pkg::CTRL_RST));
    rd(rcat_pkg::OFS_ITL, 32'hFF, 32'(rcat_pkg::ITL_RST));
    rd(rcat_pkg::OFS_CTL, 32'hFF, 32'(rcat_pkg::CTL_RST));
    rd(rcat_pkg::OFS_DELAY, 32'hFFFF, 32'(rcat_pkg::DELAY_RST));
    rd(rcat_pkg::OFS_STATUS, 32'h3FFF, 32'h0);
    rd(rcat_pkg::OFS_CMD, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'hFFFFFFFF, 32'h0});
    apb(1'b1, 8'h44, $urandom, {1'b1, 64'h0});
    wr(rcat_pkg::OFS_ITL, 32'hC8);
    rd(rcat_pkg::OFS_ITL, 32'hFF, 32'(rcat_pkg::CUTOFF_MAX));
    // Thermal cycling, non-latching
    wr(rcat_pkg::OFS_ITL, 32'h5);
    wr(rcat_pkg::OFS_CTL, 32'h2);
    wr(rcat_pkg::OFS_CTRL, 32'h41);
    pol <= 7'h02;
    h = $urandom % 4;
    lag <= 3'($urandom % 8);
    req[4+h] <= 1'b1;
    wait_out(0, 1'b1, 14);
    stay(0, 1'b1, 120);
    req[4+h] <= 1'b0;
    wait_out(0, 1'b0, 80);
    stay(0, 1'b0, 30);
    req[1] <= 1'b1;
    wait_out(1, 1'b1, 14);
    req[1] <= 1'b0;
    wait_out(1, 1'b0, 14);
    req[4+h] <= 1'b1;
    wait_out(0, 1'b1, 14);
    wait_out(0, 1'b0, 60);
    `CHK(k > CPS && k <= 3 * CPS, 1'b1)
    stay(0, 1'b0, 40);
    req[4+h] <= 1'b0;
    req[3:2] <= 2'b11;
    wait_out(3, 1'b1, 14);
    wait_out(4, 1'b1, 14);
    // Latching input
    wr(rcat_pkg::OFS_CMD, 32'h1);
    wr(rcat_pkg::OFS_CTRL, 32'h40);
    req[4+h] <= 1'b1;
    wait_out(0, 1'b1, 14);
    req[4+h] <= 1'b0;
    stay(0, 1'b1, 100);
    wr(rcat_pkg::OFS_CMD, 32'h1);
    wait_out(0, 1'b0, 4);
    // Minute units
    wr(rcat_pkg::OFS_ITL, 32'h2);
    wr(rcat_pkg::OFS_CTRL, 32'h43);
    req[4+h] <= 1'b1;
    wait_out(0, 1'b1, 14);
    req[4+h] <= 1'b0;
    wait_out(0, 1'b0, 1300);
    `CHK(k > 50 * CPS, 1'b1)
    wr(rcat_pkg::OFS_CMD, 32'h1);
    // Countdown in every abort mode
    for (int m = 0; m < 5; m++) begin
      wr(rcat_pkg::OFS_CTRL, 32'(32'h40 | (m << 2) | (m[0] << 5)));
      pol <= {5'h00, 1'b1, m[0]};
      wr(rcat_pkg::OFS_DELAY, 32'd15);
      wr(rcat_pkg::OFS_CMD, 32'h2);
      lag <= 3'($urandom % 8);
      repeat (25) @(posedge pclk);
      req[0] <= 1'b1;
      repeat (200) @(posedge pclk);
      rd(rcat_pkg::OFS_REMAIN, msk[m], 32'(rem[m]));
      rr = int'(r1[15:0]);
      if (m == 3) `CHK(rr inside {[11:14]}, 1'b1)
      stay(2, 1'(m == 4), 1);
      repeat (40) @(posedge pclk);
      rd(rcat_pkg::OFS_REMAIN, 32'hFFFF, 32'(rr));
      req[0] <= 1'b0;
      wait_out(2, 1'b1, (rr + 2) * CPS + 10);
      `CHK(k >= (rr - 1) * CPS, 1'b1)
      wr(rcat_pkg::OFS_CMD, 32'h1);
      wait_out(2, 1'b0, 4);
    end
    end_sim();
  end
endmodule

bind rcat_top rcat_chk #(.CYC_PER_SEC(CYC_PER_SEC)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .manual_reactivate_switch(manual_reactivate_switch), .notify_out_en(notify_out_en),
  .extinguish_out_en(extinguish_out_en), .release_out_en(release_out_en));
